// >>> eeba_pkg.sv
package eeba_pkg;
  // store geometry
  localparam int EEBA_DEPTH = 512;
  localparam int EEBA_AW = 9;
  localparam int EEBA_DW = 8;
  // i/o register offsets
  localparam logic [5:0] EEBA_OFS_CTRL = 6'h00;
  localparam logic [5:0] EEBA_OFS_DATA = 6'h01;
  localparam logic [5:0] EEBA_OFS_ADDR_LO = 6'h02;
  localparam logic [5:0] EEBA_OFS_ADDR_HI = 6'h03;
  // nv_control field positions
  localparam int EEBA_BIT_READ = 0;
  localparam int EEBA_BIT_STROBE = 1;
  localparam int EEBA_BIT_ARM = 2;
  localparam int EEBA_BIT_MODE_LO = 4;
  localparam int EEBA_BIT_MODE_HI = 5;
  // programming modes
  localparam logic [1:0] EEBA_MODE_ATOMIC = 2'h0;
  localparam logic [1:0] EEBA_MODE_ERASE = 2'h1;
  localparam logic [1:0] EEBA_MODE_WRITE = 2'h2;
  localparam logic [1:0] EEBA_MODE_RSVD = 2'h3;
  // reset values
  localparam logic [1:0] EEBA_MODE_RST = 2'h0;
  localparam logic [8:0] EEBA_ADDR_RST = 9'h000;
  localparam logic [7:0] EEBA_DATA_RST = 8'h00;
  // timing, windows and stalls in cycles of the 250 MHz clock, write times in us
  localparam logic [2:0] EEBA_ARM_WINDOW = 3'h4;
  localparam logic [2:0] EEBA_READ_STALL = 3'h4;
  localparam logic [2:0] EEBA_WRITE_STALL = 3'h2;
  localparam int EEBA_CLK_MHZ = 250;
  localparam int EEBA_T_ATOMIC_US = 3400;
  localparam int EEBA_T_SPLIT_US = 1800;
  localparam int EEBA_ATOMIC_CYC = EEBA_T_ATOMIC_US * EEBA_CLK_MHZ;
  localparam int EEBA_SPLIT_CYC = EEBA_T_SPLIT_US * EEBA_CLK_MHZ;
endpackage : eeba_pkg

// >>> eeba_store_if.sv
`timescale 1ns/1ps
interface eeba_store_if;
  import eeba_pkg::*;
  logic [EEBA_AW-1:0] addr;
  logic [EEBA_DW-1:0] wdata;
  logic [1:0] mode;
  logic start;
  logic busy;
  logic [EEBA_DW-1:0] rdata;
  modport ctrl (output addr, output wdata, output mode, output start,
                input busy, input rdata);
  modport store (input addr, input wdata, input mode, input start,
                 output busy, output rdata);
endinterface : eeba_store_if

// >>> eeba_store.sv
`timescale 1ns/1ps
module eeba_store
  import eeba_pkg::*;
#(
  parameter int ATOMIC_CYC = EEBA_ATOMIC_CYC,
  parameter int SPLIT_CYC = EEBA_SPLIT_CYC
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // request side
  eeba_store_if.store st
);
  localparam int CW = $clog2(ATOMIC_CYC + 1);
  typedef enum logic {ST_IDLE, ST_BUSY} eeba_state_t;

  eeba_state_t state_q;
  logic [EEBA_DW-1:0] mem [EEBA_DEPTH];
  logic [CW-1:0] cnt_q;
  logic [EEBA_AW-1:0] addr_q;
  logic [EEBA_DW-1:0] data_q;
  logic [1:0] mode_q;
  logic [CW-1:0] load_cnt;
  logic [EEBA_DW-1:0] commit_val;
  logic done;

  // erase leaves all ones; a plain write can only clear bits
  assign load_cnt = (st.mode == EEBA_MODE_ATOMIC) ? CW'(ATOMIC_CYC - 1) : CW'(SPLIT_CYC - 1);
  assign commit_val = (mode_q == EEBA_MODE_ATOMIC) ? data_q :
                      (mode_q == EEBA_MODE_ERASE) ? 8'hff : (mem[addr_q] & data_q);
  assign done = (state_q == ST_BUSY) && (cnt_q == '0);
  assign st.busy = (state_q == ST_BUSY);
  assign st.rdata = mem[st.addr];

  // self-timed write: latch request, count down, commit at the end
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
    end
    else
    begin
      unique case (state_q)
        ST_IDLE:
        begin
          if (st.start)
          begin
            state_q <= ST_BUSY; // R5
            cnt_q <= load_cnt; // R15
          end
        end
        ST_BUSY:
        begin
          if (cnt_q == '0)
            state_q <= ST_IDLE; // R14
          else
            cnt_q <= cnt_q - 1'b1;
        end
      endcase
    end
  end

  // request latch; no reset needed, only read while busy
  always_ff @(posedge clk_i)
  begin
    if (st.start && !st.busy)
    begin
      addr_q <= st.addr;
      data_q <= st.wdata;
      mode_q <= st.mode;
    end
  end

  // the array has no reset, contents survive
  always_ff @(posedge clk_i)
  begin
    if (done)
      mem[addr_q] <= commit_val; // R1 R11
  end

  chk_timer_load: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R15
    (st.start && !st.busy) |=> (st.busy && cnt_q == $past(load_cnt)))
    else $error("write timer not loaded for mode");
  chk_commit_data: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R11
    (done && mode_q == EEBA_MODE_ATOMIC) |=> (mem[$past(addr_q)] == $past(data_q)))
    else $error("atomic write did not store buffered byte");
endmodule : eeba_store

// >>> eeba_top.sv
`timescale 1ns/1ps
// Functional notes
// R1: 512 separate bytes, each individually readable and writable.
// R2: address, data and control registers sit on the cpu i/o port.
// R3: a triggered read stalls the cpu four cycles.
// R4: a started write stalls the cpu two cycles.
// R5: write is self-timed; busy state readable by software.
// R6: write only after the arm-then-strobe sequence; software must follow it.
// R7: linear address 0..511 from bits 8..0 across high and low registers.
// R8: address bits 15..9 read as zero, writes ignored.
// R9: software must load an address before any access.
// R10: software writes zero to top address bit; design keeps full 9 bits.
// R11: write stores the data byte at the selected address.
// R12: read loads the data register with the addressed byte.
// R13: arm bit self-clears four cycles after set; strobe only counts meanwhile.
// R14: write strobe clears itself when write time has elapsed.
// R15: mode field picks atomic, erase or write; ignored while busy.
// R16: read is immediate; reads and address changes blocked while busy.
module eeba_top
  import eeba_pkg::*;
#(
  parameter int ATOMIC_CYC = EEBA_ATOMIC_CYC,
  parameter int SPLIT_CYC = EEBA_SPLIT_CYC
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // cpu i/o register port
  input wire logic [5:0] io_addr_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic [7:0] io_wdata_i,
  output logic [7:0] io_rdata_o,
  // cpu hold
  output logic cpu_stall_o
);
  eeba_store_if st_if ();

  logic [EEBA_AW-1:0] nv_address_q;
  logic [EEBA_DW-1:0] nv_byte_buffer_q;
  logic [1:0] prog_mode_q;
  logic [2:0] arm_cnt_q;
  logic [2:0] arm_cnt_d;
  logic [2:0] stall_cnt_q;
  logic [2:0] stall_cnt_d;
  logic [7:0] rdata_q;
  logic stall_q;

  // register decode
  wire wr_ctrl = io_wr_i && (io_addr_i == EEBA_OFS_CTRL); // R2
  wire wr_data = io_wr_i && (io_addr_i == EEBA_OFS_DATA);
  wire wr_alo = io_wr_i && (io_addr_i == EEBA_OFS_ADDR_LO);
  wire wr_ahi = io_wr_i && (io_addr_i == EEBA_OFS_ADDR_HI);
  wire busy = st_if.busy;
  wire master_write_arm = (arm_cnt_q != 3'h0);
  wire arm_set = wr_ctrl && io_wdata_i[EEBA_BIT_ARM];
  wire strobe_req = wr_ctrl && io_wdata_i[EEBA_BIT_STROBE];
  // arm must already stand; arming and striking in one write is refused
  wire write_start = strobe_req && master_write_arm && !busy &&
                     (prog_mode_q != EEBA_MODE_RSVD); // R6 R13
  wire read_req = wr_ctrl && io_wdata_i[EEBA_BIT_READ] && !busy; // R16
  wire [1:0] prog_mode_d = {io_wdata_i[EEBA_BIT_MODE_HI], io_wdata_i[EEBA_BIT_MODE_LO]};

  // store request wiring
  assign st_if.addr = nv_address_q;
  assign st_if.wdata = nv_byte_buffer_q;
  assign st_if.mode = prog_mode_q;
  assign st_if.start = write_start;

  // read image of each register
  wire [7:0] ctrl_img = {2'h0, prog_mode_q, 1'b0, master_write_arm, busy, 1'b0}; // R14
  wire [7:0] ahi_img = {7'h00, nv_address_q[8]}; // R8
  wire [7:0] rd_mux = (io_addr_i == EEBA_OFS_CTRL) ? ctrl_img :
                      (io_addr_i == EEBA_OFS_DATA) ? nv_byte_buffer_q :
                      (io_addr_i == EEBA_OFS_ADDR_LO) ? nv_address_q[7:0] :
                      (io_addr_i == EEBA_OFS_ADDR_HI) ? ahi_img : 8'h00;

  // arm window and stall counters; a start consumes the arm
  assign arm_cnt_d = write_start ? 3'h0 : arm_set ? EEBA_ARM_WINDOW :
                     master_write_arm ? arm_cnt_q - 3'h1 : 3'h0; // R13
  assign stall_cnt_d = read_req ? EEBA_READ_STALL : write_start ? EEBA_WRITE_STALL :
                       (stall_cnt_q != 3'h0) ? stall_cnt_q - 3'h1 : 3'h0; // R3 R4

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      arm_cnt_q <= 3'h0;
      stall_cnt_q <= 3'h0;
      stall_q <= 1'b0;
    end
    else
    begin
      arm_cnt_q <= arm_cnt_d;
      stall_cnt_q <= stall_cnt_d;
      stall_q <= (stall_cnt_d != 3'h0);
    end
  end

  // address and mode are frozen during a write
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      nv_address_q <= EEBA_ADDR_RST;
      prog_mode_q <= EEBA_MODE_RST;
    end
    else
    begin
      if (wr_alo && !busy)
        nv_address_q[7:0] <= io_wdata_i; // R7 R16
      if (wr_ahi && !busy)
        nv_address_q[8] <= io_wdata_i[0]; // R7
      if (wr_ctrl && !busy)
        prog_mode_q <= prog_mode_d; // R15
    end
  end

  // data buffer: cpu writes it, a read strobe refills it
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      nv_byte_buffer_q <= EEBA_DATA_RST;
    else if (read_req)
      nv_byte_buffer_q <= st_if.rdata; // R12
    else if (wr_data)
      nv_byte_buffer_q <= io_wdata_i; // R11
  end

  // registered read data, one cycle after io_rd_i
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      rdata_q <= 8'h00;
    else if (io_rd_i)
      rdata_q <= rd_mux;
  end

  assign io_rdata_o = rdata_q;
  assign cpu_stall_o = stall_q;

  eeba_store #(
    .ATOMIC_CYC(ATOMIC_CYC),
    .SPLIT_CYC(SPLIT_CYC)
  ) u_store (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .st(st_if.store)
  );

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence arm_quiet_s;
    (!arm_set && !write_start) [*4];
  endsequence

  chk_arm_expires: assert property (arm_set ##1 arm_quiet_s |=> !master_write_arm) // R13
    else $error("arm bit did not expire after four cycles");
  chk_arm_holds: assert property ((arm_set && !write_start) ##1 arm_quiet_s // R13
    |-> master_write_arm && $past(master_write_arm, 3))
    else $error("arm bit dropped early");
  chk_read_stall: assert property (read_req |=> cpu_stall_o [*4]) // R3
    else $error("read stall shorter than four cycles");
  chk_write_stall: assert property (write_start ##1 (!read_req) [*2] |=> !cpu_stall_o) // R4
    else $error("write stall longer than two cycles");
  chk_unarmed_strobe: assert property ((strobe_req && !master_write_arm && !busy) |=> !busy) // R6
    else $error("write started without arm");
  chk_start_busy: assert property (write_start |=> busy && ctrl_img[EEBA_BIT_STROBE]) // R5 R14
    else $error("strobe not shown busy after start");
  chk_addr_frozen: assert property (busy |=> $stable(nv_address_q)) // R16
    else $error("address changed during write");
  chk_mode_frozen: assert property (busy |=> $stable(prog_mode_q)) // R15
    else $error("mode changed during write");
  chk_read_loads: assert property (read_req |=> nv_byte_buffer_q == $past(st_if.rdata)) // R12
    else $error("read did not load data register");
  chk_upper_zero: assert property ((io_rd_i && io_addr_i == EEBA_OFS_ADDR_HI)
    |=> io_rdata_o[7:1] == 7'h00) // R8
    else $error("reserved address bits not zero");

  // named steps of the guarded write: an arm on its own, then a legal strike
  sequence arm_alone_s;
    arm_set && !write_start;
  endsequence

  sequence legal_strike_s;
    strobe_req && !busy && (prog_mode_q != EEBA_MODE_RSVD);
  endsequence

  // write-side checks
  chk_strike_starts: assert property (arm_alone_s ##[1:4] legal_strike_s // R6 R13
    |-> write_start)
    else $error("armed strike inside the window did not start a write");
  chk_write_stall_min: assert property (write_start |=> cpu_stall_o [*2]) // R4
    else $error("write stall shorter than two cycles");
  chk_rsvd_refused: assert property ((strobe_req && master_write_arm && !busy && // R15
    prog_mode_q == EEBA_MODE_RSVD) |=> !busy)
    else $error("reserved mode started a write");

  // register-side checks
  chk_read_blocked: assert property ((wr_ctrl && io_wdata_i[EEBA_BIT_READ] && busy) // R16
    |=> $stable(nv_byte_buffer_q))
    else $error("read strobe acted during a write");
  chk_mode_taken: assert property ((wr_ctrl && !busy) // R15
    |=> prog_mode_q == $past(prog_mode_d))
    else $error("mode field not taken from control write");
  chk_addr_taken: assert property ((wr_alo && !busy) // R7
    |=> nv_address_q[7:0] == $past(io_wdata_i))
    else $error("low address not taken from write");
  chk_rdata_hold: assert property (!io_rd_i |=> $stable(io_rdata_o)) // R2
    else $error("read data moved without a read");

  // helper for the write-time check; its own count, so a broken store timer shows up
  logic [31:0] busy_len_q;
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || !busy)
      busy_len_q <= 32'h0;
    else
      busy_len_q <= busy_len_q + 32'h1;
  end

  // busy must last exactly the write time of the latched mode
  chk_busy_length: assert property ($fell(busy) // R5 R15
    |-> busy_len_q == ((prog_mode_q == EEBA_MODE_ATOMIC) ? 32'(ATOMIC_CYC) : 32'(SPLIT_CYC)))
    else $error("write time does not match mode");
endmodule : eeba_top

// >>> eeba_cpu_model.sv
`timescale 1ns/1ps
module eeba_cpu_model
(
  // clock
  input wire logic clk_i,
  // device answers
  input wire logic stall_i,
  input wire logic [7:0] rdata_i,
  // i/o register requests
  output logic [5:0] io_addr_o,
  output logic io_wr_o,
  output logic io_rd_o,
  output logic [7:0] io_wdata_o
);
  int n_hang;
  // idle bus at time zero
  initial
  begin
    n_hang = 0;
    io_addr_o = 6'h3f;
    io_wr_o = 1'b0;
    io_rd_o = 1'b0;
    io_wdata_o = 8'h00;
  end
  // a held cpu issues nothing until the stall drops; bounded so a stuck hold shows up
  task automatic wait_free();
    int k;
    k = 0;
    while (stall_i !== 1'b0 && k < 16)
    begin
      @(negedge clk_i);
      k++;
    end
    if (k == 16)
      n_hang++;
  endtask : wait_free
  // one-cycle write; released lines show the inverse so stale values never match
  task automatic wr(input logic [5:0] a, input logic [7:0] d, input int ncyc, output int nst);
    @(negedge clk_i);
    wait_free();
    io_addr_o = a;
    io_wdata_o = d;
    io_wr_o = 1'b1;
    @(negedge clk_i);
    io_wr_o = 1'b0;
    io_addr_o = ~a;
    io_wdata_o = ~d;
    nst = 0;
    // count hold cycles after the taking edge
    repeat (ncyc)
    begin
      if (stall_i === 1'b1)
        nst++;
      @(negedge clk_i);
    end
  endtask : wr
  // one-cycle read; data sampled a full cycle later, where it stands either way
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(negedge clk_i);
    wait_free();
    io_addr_o = a;
    io_rd_o = 1'b1;
    @(negedge clk_i);
    io_rd_o = 1'b0;
    io_addr_o = ~a;
    @(negedge clk_i);
    d = rdata_i;
  endtask : rd
endmodule : eeba_cpu_model

// >>> eeba_top_tb_top.sv
`timescale 1ns/1ps
module eeba_top_tb_top;
  import eeba_pkg::*;
  // short write times keep the run small
  localparam int T_ATOM = 20;
  localparam int T_SPLIT = 10;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [5:0] io_addr;
  logic io_wr;
  logic io_rd;
  logic [7:0] io_wdata;
  logic [7:0] io_rdata;
  logic stall;
  int n_fail = 0;
  int total_checks = 0;
  logic [7:0] mem [0:511];
  always #2 clk_i = ~clk_i;
  eeba_top #(.ATOMIC_CYC(T_ATOM), .SPLIT_CYC(T_SPLIT)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .io_addr_i(io_addr), .io_wr_i(io_wr), .io_rd_i(io_rd), .io_wdata_i(io_wdata),
    .io_rdata_o(io_rdata), .cpu_stall_o(stall));
  eeba_cpu_model cpu (.clk_i(clk_i), .stall_i(stall), .rdata_i(io_rdata), .io_addr_o(io_addr),
    .io_wr_o(io_wr), .io_rd_o(io_rd), .io_wdata_o(io_wdata));
  // expected control read: mode field and busy flag, all else zero
  function automatic logic [7:0] ctrl_exp(input logic [1:0] m, input logic busy);
    return {2'h0, m, 2'h0, busy, 1'b0};
  endfunction : ctrl_exp
  // expected byte after a completed write of each mode
  function automatic logic [7:0] store_exp(input logic [1:0] m, input logic [7:0] old,
                                           input logic [7:0] d);
    case (m)
      EEBA_MODE_ATOMIC: return d;
      EEBA_MODE_ERASE: return 8'hff;
      EEBA_MODE_WRITE: return old & d;
      default: return old;
    endcase
  endfunction : store_exp
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic finish_test();
    chk(8'(cpu.n_hang), 8'h00);
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test
  task automatic set_addr(input logic [8:0] a);
    int n;
    cpu.wr(EEBA_OFS_ADDR_HI, {7'h00, a[8]}, 0, n);
    cpu.wr(EEBA_OFS_ADDR_LO, a[7:0], 0, n);
  endtask : set_addr
  // read strobe, hold count, then the data register
  task automatic rd_byte(input logic [8:0] a);
    int n;
    logic [7:0] v;
    set_addr(a);
    cpu.wr(EEBA_OFS_CTRL, 8'h01, 6, n);
    chk(8'(n), 8'h04);
    cpu.rd(EEBA_OFS_DATA, v);
    chk(v, mem[a]);
  endtask : rd_byte
  // arm, wait gap cycles, strobe; gap below zero sends arm and strobe together
  task automatic nv_write(input logic [8:0] a, input logic [7:0] d, input logic [1:0] m,
                          input int gap, input logic go);
    int n;
    int k;
    logic [7:0] v;
    set_addr(a);
    cpu.wr(EEBA_OFS_DATA, d, 0, n);
    if (gap >= 0)
      cpu.wr(EEBA_OFS_CTRL, {2'h0, m, 4'h4}, gap, n);
    cpu.wr(EEBA_OFS_CTRL, {2'h0, m, 4'h6}, 6, n);
    chk(8'(n), go ? 8'h02 : 8'h00);
    cpu.rd(EEBA_OFS_CTRL, v);
    chk(v, ctrl_exp(m, go));
    // long write only: address, mode and read must all bounce off while busy
    if (go && m == EEBA_MODE_ATOMIC)
    begin
      cpu.wr(EEBA_OFS_ADDR_LO, ~a[7:0], 0, n);
      cpu.wr(EEBA_OFS_CTRL, 8'h31, 6, n);
      chk(8'(n), 8'h00);
      cpu.rd(EEBA_OFS_DATA, v);
      chk(v, d);
      cpu.rd(EEBA_OFS_CTRL, v);
    end
    k = 0;
    while (v[EEBA_BIT_STROBE] !== 1'b0 && k < 200)
    begin
      cpu.rd(EEBA_OFS_CTRL, v);
      k++;
    end
    if (k == 200)
    begin
      n_fail++;
      finish_test();
    end
    chk(v, ctrl_exp(m, 1'b0));
    cpu.rd(EEBA_OFS_ADDR_LO, v);
    chk(v, a[7:0]);
    if (go)
      mem[a] = store_exp(m, mem[a], d);
    rd_byte(a);
  endtask : nv_write
  initial
  begin
    logic [7:0] v;
    logic [8:0] a;
    logic [7:0] d;
    int n;
    void'($urandom(32'h1e27469f));
    repeat (16) @(negedge clk_i);
    rst_n_i = 1'b1;
    // reset values, offset 4 is unmapped
    for (int o = 0; o < 5; o++)
    begin
      cpu.rd(6'(o), v);
      chk(v, 8'h00);
    end
    cpu.wr(EEBA_OFS_ADDR_HI, 8'hff, 0, n);
    cpu.rd(EEBA_OFS_ADDR_HI, v);
    chk(v, 8'h01);
    $display("test reset_and_address done");
    // random bytes plus both ends of the store, every mode and refusal
    for (int i = 0; i < 6; i++)
    begin
      a = 9'($urandom_range(511));
      d = 8'($urandom);
      if (i == 0)
        a = 9'h1ff;
      if (i == 1)
        a = 9'h000;
      nv_write(a, d, EEBA_MODE_ATOMIC, 0, 1'b1);
      nv_write(a, ~d | 8'($urandom), EEBA_MODE_WRITE, 2, 1'b1);
      nv_write(a, 8'($urandom), EEBA_MODE_ERASE, 1, 1'b1);
      nv_write(a, d, EEBA_MODE_ATOMIC, 3, 1'b0);
      nv_write(a, d, EEBA_MODE_ATOMIC, -1, 1'b0);
      nv_write(a, d, EEBA_MODE_RSVD, 0, 1'b0);
      $display("test write_modes %0d done", i);
    end
    // reset in mid-write abandons the write and leaves the byte alone
    set_addr(a);
    cpu.wr(EEBA_OFS_DATA, ~mem[a], 0, n);
    cpu.wr(EEBA_OFS_CTRL, 8'h04, 0, n);
    cpu.wr(EEBA_OFS_CTRL, 8'h06, 2, n);
    chk(8'(n), 8'h02);
    rst_n_i = 1'b0;
    repeat (2) @(negedge clk_i);
    rst_n_i = 1'b1;
    cpu.rd(EEBA_OFS_CTRL, v);
    chk(v, 8'h00);
    rd_byte(a);
    $display("test reset_mid_write done");
    finish_test();
  end
endmodule : eeba_top_tb_top
